/* rtl/charger_irq_consts.svh */
`ifndef CHARGER_IRQ_CONSTS_SVH
`define CHARGER_IRQ_CONSTS_SVH

// ----------------------------------------
// Register byte offsets on the AHB-Lite slave.
// ----------------------------------------
`define CIS_OFS_LIVE      8'h00
`define CIS_OFS_LATCHED   8'h04
`define CIS_OFS_BLOCK     8'h08
`define CIS_OFS_DISABLE   8'h0C
`define CIS_OFS_CONTROL   8'h10
`define CIS_OFS_CONFIG    8'h14

// ----------------------------------------
// Field positions.
// ----------------------------------------
`define CIS_CTL_CHARGE_ENABLE_BIT    0
`define CIS_CTL_ADC_EN    1
`define CIS_CTL_MEASURE   2
`define CIS_CTL_OVP_LSB   8
`define CIS_CFG_ROLE_LSB  8
`define CIS_CFG_OVP_LSB   16
`define CIS_CFG_BEGUN     24
`define CIS_CFG_STATE_LSB 25

// ----------------------------------------
// Source bit positions inside the status vectors.
// ----------------------------------------
`define CIS_SRC_VAC_OVP   0
`define CIS_SRC_SW_OC     10

// ----------------------------------------
// Reset values.
// ----------------------------------------
`define CIS_RST_BLOCK     16'h0000
`define CIS_RST_DISABLE   16'h0000
`define CIS_RST_OVP       8'h00

// ----------------------------------------
// Source groups and availability per operating state.
// ----------------------------------------
`define CIS_FAULT_BITS    16'h07FF
`define CIS_AVAIL_BATT    16'h0000
`define CIS_AVAIL_IDLE    16'h01C1
`define CIS_AVAIL_ADC     16'h03E1
`define CIS_AVAIL_SOFT    16'h7FFF
`define CIS_AVAIL_CHG     16'hFFFF

// ----------------------------------------
// Bus addresses and over-voltage defaults (0.1 V steps, zero is disabled).
// ----------------------------------------
`define CIS_ADDR_65       7'h65
`define CIS_ADDR_66       7'h66
`define CIS_ADDR_67       7'h67
`define CIS_OVP_6V5       8'h41
`define CIS_OVP_11V       8'h6E
`define CIS_OVP_OFF       8'h00

// ----------------------------------------
// Timing.
// ----------------------------------------
`define CIS_CLK_PERIOD_NS 8
`define CIS_T_INT_NS      256000
`define CIS_OC_CYCLES     16

`endif

/* rtl/charger_irq_pkg.sv */
package charger_irq_pkg;

	// Operating role chosen by the strap resistor.
	typedef enum logic [1:0] {role_master, role_slave, role_standalone} role_type;

	// Strap resistor codes delivered by the strap comparator.
	typedef enum logic [1:0] {strap_18k, strap_39k, strap_75k, strap_open} strap_type;

	// Operating state that decides which protections are armed.
	typedef enum logic [2:0] {st_batt_only, st_idle, st_idle_adc, st_soft_start,
		st_charging} op_state_type;

	// Latched AHB-Lite address phase.
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} ahb_req_type;

	// Pins and analog comparator outputs from outside the clock domain.
	typedef struct packed {
		logic [15:0] fault_cond;
		logic        vac_present;
		logic        soft_start;
		logic        switch_oc;
		logic        switch_clk;
		logic [1:0]  strap_code;
		logic        alt_addr;
		logic        temp_pin;
		logic        batsense_pin;
	} pin_in_type;

endpackage

/* rtl/charger_interrupt_status.sv */
// Function
// - Alert pin is open-drain pull-down only.
// - Alert pulls low for fixed pulse, releases.
// - Live status follows source condition continuously.
// - Event flags set, cleared by host read.
// - Persistent condition gives no repeat alert.
// - Block bit stops alert; status still updates.
// - Blocked source still performs protective action.
// - Disabled source held reset, no alert.
// - Any fault trip turns blocking switch off.
// - Strap and alt bit select bus address.
// - Strap sets over-voltage default and role.
// - After host control write, register sets limit.
// - Master: sync out, battery sense pins.
// - Slave: temperature sense, sync in pins.
// - Master and standalone drive input guard gate; slave does not.
// - Measurement requests accepted in every state.
// - Input range check only when ADC/soft/charging.
// - Switch current limit armed soft-start, charging.
// - Input faults clear charge enable bit.
// - Sixteen overcurrent cycles stop, flag, alert.
// - Undercurrent alarm notifies, keeps charge, blanked.
`include "charger_irq_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module charger_interrupt_status #(
	parameter int SRC_W            = 16,
	parameter int INT_PULSE_CYCLES =
		(`CIS_T_INT_NS + `CIS_CLK_PERIOD_NS - 1) / `CIS_CLK_PERIOD_NS
) (
	input  wire logic                    hclk,
	input  wire logic                    hresetn,
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic      [31:0]             hrdata,
	output logic                         hreadyout,
	output logic                         hresp,
	input  wire charger_irq_pkg::pin_in_type pins_raw,
	input  wire logic                    phase_sync_src,
	output logic                         alert_n_out,
	output logic                         alert_n_oe,
	output logic                         input_guard_gate_out,
	output logic                         input_guard_gate_oe,
	output logic                         phase_sync_out,
	output logic                         temp_or_sync_out_pin_oe,
	output logic                         batsense_or_sync_in_pin_oe,
	output logic                         battery_temp_sense,
	output logic                         phase_sync_in,
	output logic                         battery_sense_pos_sel,
	output logic                         block_switch_on,
	output logic                         switching_enable,
	output logic                         adc_enable,
	output logic                         measure_start,
	output logic      [6:0]              bus_addr,
	output charger_irq_pkg::role_type    role,
	output logic      [7:0]              input_overvolt_limit
);

	// ----------------------------------------
	// Elaboration checks.
	// ----------------------------------------
	if (SRC_W != 16) $error("SRC_W must be 16 to match the source map.");
	if (INT_PULSE_CYCLES < 1) $error("INT_PULSE_CYCLES must be at least one.");

	// ----------------------------------------
	// Declarations.
	// ----------------------------------------
	charger_irq_pkg::pin_in_type   pins_meta;       // First synchroniser stage.
	charger_irq_pkg::pin_in_type   pins_s;          // Second synchroniser stage.
	charger_irq_pkg::ahb_req_type  req;             // Latched address phase.
	charger_irq_pkg::op_state_type op_state;        // Present operating state.
	logic [SRC_W-1:0]  fault_live_state;            // Live status vector.
	logic [SRC_W-1:0]  live_prev;                   // Live status one cycle ago.
	logic [SRC_W-1:0]  fault_latched;               // Sticky event flags.
	logic [SRC_W-1:0]  fault_alert_block;           // Alert mask bits.
	logic [SRC_W-1:0]  source_disable;              // Source disable bits.
	logic [SRC_W-1:0]  avail;                       // Sources armed in this state.
	logic [SRC_W-1:0]  next_live;                   // Live status to be stored.
	logic [SRC_W-1:0]  new_event;                   // Rising edges of live status.
	logic [SRC_W-1:0]  read_clear;                  // Flags cleared by this read.
	logic              charge_enable_bit;           // Host charge enable.
	logic [7:0]        ovp_reg;                     // Host over-voltage limit.
	logic [7:0]        ovp_default;                 // Strap over-voltage default.
	logic              comm_begun;                  // Host has written control.
	logic              strap_taken;                 // Strap captured after reset.
	logic              sw_clk_prev;                 // Switch clock, delayed.
	logic              cycle_tick;                  // One pulse per switch cycle.
	logic [4:0]        oc_count;                    // Consecutive overcurrent cycles.
	logic              oc_trip;                     // Cycle limit has tripped.
	logic [31:0]       alert_count;                 // Remaining alert pulse cycles.
	logic              addr_phase;                  // Valid address phase now.
	logic              ctl_write;                   // Data phase writes control.
	logic              fault_trip;                  // Any fault source is live.

	// ----------------------------------------
	// Input synchroniser.
	// ----------------------------------------

	// Every pin passes two flip-flops before any logic looks at it.
	// The stages keep running through reset, so the strap is settled
	// by the time the first edge after release captures it.
	always_ff @(posedge hclk)
	begin
		pins_meta <= pins_raw;
		pins_s    <= pins_meta;
	end

	// ----------------------------------------
	// Operating state and availability.
	// ----------------------------------------

	// The state follows input presence, soft-start, the charge bit and the ADC enable.
	always_comb
	begin
		if (!pins_s.vac_present)
			op_state = charger_irq_pkg::st_batt_only;
		else if (charge_enable_bit && pins_s.soft_start)
			op_state = charger_irq_pkg::st_soft_start;
		else if (charge_enable_bit)
			op_state = charger_irq_pkg::st_charging;
		else if (adc_enable)
			op_state = charger_irq_pkg::st_idle_adc;
		else
			op_state = charger_irq_pkg::st_idle;
	end

	// Each state arms its own set of checks.
	always_comb
	begin
		case (op_state)
			charger_irq_pkg::st_idle:       avail = `CIS_AVAIL_IDLE;
			charger_irq_pkg::st_idle_adc:   avail = `CIS_AVAIL_ADC;
			charger_irq_pkg::st_soft_start: avail = `CIS_AVAIL_SOFT;
			charger_irq_pkg::st_charging:   avail = `CIS_AVAIL_CHG;
			default:                        avail = `CIS_AVAIL_BATT;
		endcase
	end

	// ----------------------------------------
	// Cycle-by-cycle current limit.
	// ----------------------------------------

	// A rising edge of the synchronised switch clock marks one cycle.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sw_clk_prev <= 1'b0;
		else
			sw_clk_prev <= pins_s.switch_clk;
	end

	assign cycle_tick = pins_s.switch_clk && !sw_clk_prev;

	// Count consecutive overcurrent cycles while the limit is armed.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			oc_count <= 5'h00;
			oc_trip  <= 1'b0;
		end
		else if (!avail[`CIS_SRC_SW_OC] || source_disable[`CIS_SRC_SW_OC])
		begin
			oc_count <= 5'h00;
			oc_trip  <= 1'b0;
		end
		else if (cycle_tick)
		begin
			if (!pins_s.switch_oc)
				oc_count <= 5'h00;
			else if (oc_count == 5'(`CIS_OC_CYCLES - 1))
				oc_trip <= 1'b1;
			else
				oc_count <= oc_count + 5'h01;
		end
	end

	// ----------------------------------------
	// Live status and event flags.
	// ----------------------------------------

	// Live status follows the sources, gated by state and disable bits.
	always_comb
	begin
		next_live                  = pins_s.fault_cond;
		next_live[`CIS_SRC_SW_OC]  = oc_trip;
		next_live                  = next_live & avail & ~source_disable;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			fault_live_state <= '0;
			live_prev        <= '0;
		end
		else
		begin
			fault_live_state <= next_live;
			live_prev        <= fault_live_state;
		end
	end

	assign new_event = fault_live_state & ~live_prev;

	// A read of the flag register clears exactly what it returned.
	assign addr_phase = hsel && hready && htrans[1];
	assign read_clear = (addr_phase && !hwrite && haddr[7:0] == `CIS_OFS_LATCHED) ?
		fault_latched : '0;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			fault_latched <= '0;
		else
			fault_latched <= ((fault_latched & ~read_clear) | new_event) & ~source_disable;
	end

	// ----------------------------------------
	// Alert pulse.
	// ----------------------------------------

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			alert_count <= 32'h0000_0000;
		else if (alert_count == 32'h0000_0000 &&
			|(new_event & ~fault_alert_block & ~source_disable))
			alert_count <= 32'(INT_PULSE_CYCLES);
		else if (alert_count != 32'h0000_0000)
			alert_count <= alert_count - 32'h0000_0001;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			alert_n_out <= 1'b0;
			alert_n_oe  <= 1'b0;
		end
		else
		begin
			alert_n_out <= 1'b0;
			alert_n_oe  <= (alert_count > 32'h0000_0001) ||
				(alert_count == 32'h0000_0000 &&
				|(new_event & ~fault_alert_block & ~source_disable));
		end
	end

	// ----------------------------------------
	// Protective action.
	// ----------------------------------------

	assign fault_trip = |(fault_live_state & `CIS_FAULT_BITS);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			block_switch_on  <= 1'b0;
			switching_enable <= 1'b0;
		end
		else
		begin
			block_switch_on  <= charge_enable_bit && !fault_trip;
			switching_enable <= charge_enable_bit && !fault_trip;
		end
	end

	// ----------------------------------------
	// Strap decode.
	// ----------------------------------------

	// The strap is caught once, on the first edge after reset release.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			strap_taken <= 1'b0;
			bus_addr    <= 7'h00;
			role        <= charger_irq_pkg::role_standalone;
			ovp_default <= `CIS_RST_OVP;
		end
		else if (!strap_taken)
		begin
			strap_taken <= 1'b1;
			case (charger_irq_pkg::strap_type'(pins_s.strap_code))
				charger_irq_pkg::strap_18k:
				begin
					bus_addr    <= pins_s.alt_addr ? `CIS_ADDR_66 : `CIS_ADDR_65;
					ovp_default <= `CIS_OVP_6V5;
					role        <= charger_irq_pkg::role_master;
				end
				charger_irq_pkg::strap_39k:
				begin
					bus_addr    <= pins_s.alt_addr ? `CIS_ADDR_67 : `CIS_ADDR_66;
					ovp_default <= `CIS_OVP_OFF;
					role        <= charger_irq_pkg::role_slave;
				end
				charger_irq_pkg::strap_75k:
				begin
					bus_addr    <= pins_s.alt_addr ? `CIS_ADDR_67 : `CIS_ADDR_65;
					ovp_default <= `CIS_OVP_11V;
					role        <= charger_irq_pkg::role_standalone;
				end
				default:
				begin
					bus_addr    <= pins_s.alt_addr ? `CIS_ADDR_67 : `CIS_ADDR_66;
					ovp_default <= `CIS_OVP_6V5;
					role        <= charger_irq_pkg::role_standalone;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			input_overvolt_limit <= `CIS_RST_OVP;
		else
			input_overvolt_limit <= comm_begun ? ovp_reg : ovp_default;
	end

	// ----------------------------------------
	// Dual-purpose pins and guard gate.
	// ----------------------------------------

	// Pin roles switch with the strap-selected role.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			phase_sync_out             <= 1'b0;
			temp_or_sync_out_pin_oe    <= 1'b0;
			batsense_or_sync_in_pin_oe <= 1'b0;
			battery_temp_sense         <= 1'b0;
			phase_sync_in              <= 1'b0;
			battery_sense_pos_sel      <= 1'b0;
			input_guard_gate_out       <= 1'b0;
			input_guard_gate_oe        <= 1'b0;
		end
		else
		begin
			phase_sync_out          <= phase_sync_src;
			temp_or_sync_out_pin_oe <= role == charger_irq_pkg::role_master;
			battery_sense_pos_sel   <= role != charger_irq_pkg::role_slave;
			battery_temp_sense      <= (role != charger_irq_pkg::role_master) &&
				pins_s.temp_pin;
			phase_sync_in           <= (role == charger_irq_pkg::role_slave) &&
				pins_s.batsense_pin;
			batsense_or_sync_in_pin_oe <= 1'b0;
			input_guard_gate_oe     <= role != charger_irq_pkg::role_slave;
			input_guard_gate_out    <= pins_s.vac_present &&
				!fault_live_state[`CIS_SRC_VAC_OVP];
		end
	end

	// ----------------------------------------
	// AHB-Lite slave.
	// ----------------------------------------

	// The address phase is latched for the following data phase.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			req <= '0;
		else
		begin
			req.valid <= addr_phase;
			req.write <= hwrite;
			req.addr  <= haddr[7:0];
		end
	end

	// The slave never stalls and always answers OKAY.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Read data is prepared at the address phase edge.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (addr_phase && !hwrite)
		begin
			if (haddr[7:0] == `CIS_OFS_LIVE)
				hrdata <= {16'h0000, fault_live_state};
			else if (haddr[7:0] == `CIS_OFS_LATCHED)
				hrdata <= {16'h0000, fault_latched};
			else if (haddr[7:0] == `CIS_OFS_BLOCK)
				hrdata <= {16'h0000, fault_alert_block};
			else if (haddr[7:0] == `CIS_OFS_DISABLE)
				hrdata <= {16'h0000, source_disable};
			else if (haddr[7:0] == `CIS_OFS_CONTROL)
				hrdata <= {16'h0000, ovp_reg, 6'h00, adc_enable, charge_enable_bit};
			else if (haddr[7:0] == `CIS_OFS_CONFIG)
				hrdata <= {4'h0, op_state, comm_begun, input_overvolt_limit, 6'h00,
					role, 1'b0, bus_addr};
			else
				hrdata <= 32'h0000_0000;
		end
	end

	assign ctl_write = req.valid && req.write && req.addr == `CIS_OFS_CONTROL;

	// Block and disable registers are plain read-write words.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			fault_alert_block <= `CIS_RST_BLOCK;
			source_disable    <= `CIS_RST_DISABLE;
		end
		else if (req.valid && req.write)
		begin
			if (req.addr == `CIS_OFS_BLOCK)
				fault_alert_block <= hwdata[15:0];
			else if (req.addr == `CIS_OFS_DISABLE)
				source_disable <= hwdata[15:0];
		end
	end

	// Control register; a live fault beats a host write of charge enable.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			charge_enable_bit <= 1'b0;
			adc_enable        <= 1'b0;
			ovp_reg           <= `CIS_RST_OVP;
			comm_begun        <= 1'b0;
		end
		else
		begin
			if (ctl_write)
			begin
				adc_enable <= hwdata[`CIS_CTL_ADC_EN];
				ovp_reg    <= hwdata[`CIS_CTL_OVP_LSB +: 8];
				comm_begun <= 1'b1;
			end
			if (fault_trip)
				charge_enable_bit <= 1'b0;
			else if (ctl_write)
				charge_enable_bit <= hwdata[`CIS_CTL_CHARGE_ENABLE_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			measure_start <= 1'b0;
		else
			measure_start <= ctl_write && hwdata[`CIS_CTL_MEASURE];
	end

endmodule // charger_interrupt_status

`default_nettype wire

/* sim/charger_irq_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Alert, trip, pin role and measure pulse checks.
// ----------------------------------------
module charger_irq_props #(
	parameter int INT_PULSE_CYCLES = 8
) (
	input wire logic                        hclk,
	input wire logic                        hresetn,
	input wire charger_irq_pkg::pin_in_type pins_raw,
	input wire logic                        phase_sync_src,
	input wire logic                        alert_n_out,
	input wire logic                        alert_n_oe,
	input wire logic                        input_guard_gate_oe,
	input wire logic                        phase_sync_out,
	input wire logic                        temp_or_sync_out_pin_oe,
	input wire logic                        batsense_or_sync_in_pin_oe,
	input wire logic                        block_switch_on,
	input wire logic                        measure_start,
	input wire charger_irq_pkg::role_type   role
);
	logic [31:0] low_cnt; // Cycles the alert has been pulled so far.

	// Counts the length of each alert pulse.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			low_cnt <= 32'h0000_0000;
		else if (alert_n_oe)
			low_cnt <= low_cnt + 32'h0000_0001;
		else
			low_cnt <= 32'h0000_0000;
	end

	a_drain: assert property (p_drain) else $error("alert driven high");
	property p_drain;
		@(posedge hclk) disable iff (!hresetn) alert_n_out == 1'b0;
	endproperty
	a_len_max: assert property (p_len_max) else $error("alert too long");
	property p_len_max;
		@(posedge hclk) disable iff (!hresetn) alert_n_oe |-> low_cnt < INT_PULSE_CYCLES;
	endproperty
	a_len_exact: assert property (p_len_exact) else $error("alert length");
	property p_len_exact;
		@(posedge hclk) disable iff (!hresetn)
			$fell(alert_n_oe) |-> $past(low_cnt) == INT_PULSE_CYCLES - 1;
	endproperty
	a_trip: assert property (p_trip) else $error("switch on in fault");
	property p_trip;
		@(posedge hclk) disable iff (!hresetn)
			(pins_raw.fault_cond[0] && pins_raw.vac_present) [*6] |=> !block_switch_on;
	endproperty
	a_gate_slave: assert property (p_gate_slave) else $error("slave drives gate");
	property p_gate_slave;
		@(posedge hclk) disable iff (!hresetn)
			role == charger_irq_pkg::role_slave && $past(role) == charger_irq_pkg::role_slave
			|-> !input_guard_gate_oe;
	endproperty
	a_pins_slave: assert property (p_pins_slave) else $error("slave pin driven");
	property p_pins_slave;
		@(posedge hclk) disable iff (!hresetn) role == charger_irq_pkg::role_slave
			|-> !temp_or_sync_out_pin_oe && !batsense_or_sync_in_pin_oe;
	endproperty
	a_sync_master: assert property (p_sync_master) else $error("master sync");
	property p_sync_master;
		@(posedge hclk) disable iff (!hresetn)
			role == charger_irq_pkg::role_master && $past(role) == charger_irq_pkg::role_master
			|-> temp_or_sync_out_pin_oe && !batsense_or_sync_in_pin_oe
			&& phase_sync_out == $past(phase_sync_src);
	endproperty
	a_meas: assert property (p_meas) else $error("measure pulse long");
	property p_meas;
		@(posedge hclk) disable iff (!hresetn) measure_start |=> !measure_start;
	endproperty
endmodule // charger_irq_props

bind charger_interrupt_status charger_irq_props #(.INT_PULSE_CYCLES(INT_PULSE_CYCLES)) props (
	.hclk(hclk), .hresetn(hresetn), .pins_raw(pins_raw), .phase_sync_src(phase_sync_src),
	.alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe),
	.input_guard_gate_oe(input_guard_gate_oe), .phase_sync_out(phase_sync_out),
	.temp_or_sync_out_pin_oe(temp_or_sync_out_pin_oe),
	.batsense_or_sync_in_pin_oe(batsense_or_sync_in_pin_oe),
	.block_switch_on(block_switch_on), .measure_start(measure_start), .role(role));
`default_nettype wire

/* sim/host_alert_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host side of the alert line.
// ----------------------------------------
module host_alert_model (
	input wire logic   hclk,
	input wire logic   hresetn,
	input wire logic   alert_n_oe,
	output logic       alert_pin,
	output logic [31:0] pulses
);
	logic pin_d; // Pin level one cycle ago.

	assign alert_pin = alert_n_oe ? 1'b0 : 1'b1;

	// Counts each falling edge of the pin as one alert.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_d <= 1'b1;
			pulses <= 32'h0000_0000;
		end
		else
		begin
			pin_d <= alert_pin;
			if (pin_d && !alert_pin)
				pulses <= pulses + 32'h0000_0001;
		end
	end
endmodule // host_alert_model
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, sync_src, alert_oe, alert_pin;
	logic block_on, sw_en, meas, meas_seen, rd_pend;
	logic [31:0] haddr, hwdata, hrdata, pulses;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [6:0] bus_addr;
	logic [7:0] ovp_lim, ovp;
	charger_irq_pkg::pin_in_type pins;
	charger_irq_pkg::role_type role;
	logic [31:0] q [$]; // Expected read data, oldest first.
	int errors, checks, cyc;
	logic [6:0] addr_tab [8] = '{7'h65, 7'h66, 7'h65, 7'h66, 7'h66, 7'h67, 7'h67, 7'h67};
	logic [7:0] ovp_tab [4] = '{8'h41, 8'h00, 8'h6E, 8'h41};
	logic [1:0] role_tab [4] = '{2'h0, 2'h1, 2'h2, 2'h2};

	assign hready = hreadyout;
	charger_interrupt_status #(.INT_PULSE_CYCLES(8)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(), .pins_raw(pins), .phase_sync_src(sync_src),
		.alert_n_out(), .alert_n_oe(alert_oe), .input_guard_gate_out(),
		.input_guard_gate_oe(), .phase_sync_out(), .temp_or_sync_out_pin_oe(),
		.batsense_or_sync_in_pin_oe(), .battery_temp_sense(), .phase_sync_in(),
		.battery_sense_pos_sel(), .block_switch_on(block_on), .switching_enable(sw_en),
		.adc_enable(), .measure_start(meas), .bus_addr(bus_addr), .role(role),
		.input_overvolt_limit(ovp_lim));
	host_alert_model host (.hclk(hclk), .hresetn(hresetn), .alert_n_oe(alert_oe),
		.alert_pin(alert_pin), .pulses(pulses));

	initial
	begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	// Prints the verdict and ends the run.
	task wrap_up();
		if (errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task wt(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// One single word transfer: address phase, then data phase.
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		bus(1'b0, a, 32'h0000_0000);
	endtask

	task do_reset();
		hresetn <= 1'b0;
		wt(10);
		hresetn <= 1'b1;
		wt(3);
	endtask

	// Notes reads taken and measure pulses; counts cycles against a hang.
	always @(posedge hclk)
	begin
		rd_pend <= hsel && hready && htrans[1] && !hwrite;
		if (meas === 1'b1)
			meas_seen <= 1'b1;
		sync_src <= 1'($urandom);
		cyc++;
		if (cyc == 4000)
		begin
			errors++;
			wrap_up();
		end
	end

	// Compares read data in mid data phase with the oldest note.
	always @(negedge hclk)
		if (rd_pend)
			chk(hrdata, q.pop_front());

	initial
	begin
		hresetn = 1'b0;
		{hsel, hwrite, rd_pend, meas_seen, sync_src} = 5'h00;
		{haddr, hwdata, htrans} = '0;
		hsize = 3'b010;
		pins = '0;
		{errors, checks, cyc} = '0;
		void'($urandom(32'h0000_09be));
		ovp = 8'($urandom_range(254, 1));
		for (int i = 0; i < 8; i++)
		begin
			pins.strap_code <= i[1:0];
			pins.alt_addr <= i[2];
			do_reset();
			chk(32'(bus_addr), 32'(addr_tab[i]));
			chk(32'(ovp_lim), 32'(ovp_tab[i[1:0]]));
			chk(32'(role), 32'(role_tab[i[1:0]]));
		end
		bus(1'b1, 8'h10, {16'h0000, ovp, 8'h04});
		wt(3);
		chk(32'(ovp_lim), 32'(ovp));
		chk(32'(meas_seen), 32'h0000_0001);
		pins.fault_cond <= 16'h0200;
		wt(8);
		rd(8'h00, 32'h0000_0000);
		pins.vac_present <= 1'b1;
		bus(1'b1, 8'h10, {16'h0000, ovp, 8'h02});
		wt(8);
		rd(8'h00, 32'h0000_0200);
		rd(8'h04, 32'h0000_0200);
		pins.fault_cond <= 16'h0000;
		bus(1'b1, 8'h10, {16'h0000, ovp, 8'h00});
		wt(8);
		pins.fault_cond <= 16'h00C0;
		wt(14);
		chk(pulses, 32'h0000_0002);
		rd(8'h04, 32'h0000_00C0);
		rd(8'h00, 32'h0000_00C0);
		rd(8'h04, 32'h0000_0000);
		wt(14);
		chk(pulses, 32'h0000_0002);
		pins.fault_cond <= 16'h0000;
		bus(1'b1, 8'h08, 32'h0000_0001);
		bus(1'b1, 8'h10, {16'h0000, ovp, 8'h01});
		wt(6);
		rd(8'h00, 32'h0000_0000);
		chk(32'({block_on, sw_en}), 32'h0000_0003);
		pins.fault_cond <= 16'h0001;
		wt(14);
		chk(32'({block_on, sw_en}), 32'h0000_0000);
		chk(pulses, 32'h0000_0002);
		rd(8'h04, 32'h0000_0001);
		rd(8'h00, 32'h0000_0001);
		rd(8'h10, {16'h0000, ovp, 8'h00});
		rd(8'h08, 32'h0000_0001);
		pins.fault_cond <= 16'h0000;
		bus(1'b1, 8'h08, 32'h0000_0000);
		bus(1'b1, 8'h0C, 32'h0000_0100);
		pins.fault_cond <= 16'h0100;
		wt(14);
		rd(8'h04, 32'h0000_0000);
		rd(8'h00, 32'h0000_0000);
		rd(8'h20, 32'h0000_0000);
		chk(pulses, 32'h0000_0002);
		// limit ignored while idle, armed while charging.
		pins.switch_oc <= 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			repeat (40)
			begin
				pins.switch_clk <= ~pins.switch_clk;
				wt(1);
			end
			rd(8'h04, {21'h00_0000, k[0], 10'h000});
			rd(8'h10, {16'h0000, ovp, 8'h00});
			bus(1'b1, 8'h10, {16'h0000, ovp, 8'h01});
		end
		chk(pulses, 32'h0000_0003);
		wt(4);
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
